// file: prhc_core.sv
// Purpose: Reference priority selection, loss-of-signal revalidation and holdover control
// Assumes: lcm_tick is a one-cycle strobe per common-multiple cycle
// Notes:   Registers reached over a plain byte-wide write/read port
//
// How it works
// - The first priority field names the preferred reference when it is available.
// - Unavailable first choice falls to the second field, then to the third.
// - Unavailable third choice falls to the fourth field in bits seven to six.
// - A returning input waits the programmed common-multiple cycles before leaving loss.
// - Timer code 000 gives no hysteresis and codes 001 to 111 give 2 up to 128 cycles.
// - Revalidation takes twice the count, or three times if another input is in loss.
// - On holdover exit code 00 resets dividers, 01 and 10 do nothing, 11 assists tuning.
// - Holdover exits when loss clears, on zero phase error with loss cleared (01), or at once (11).
// - Tracking disabled in holdover loads the seven-bit value as an unsigned word.
// - Tracking enabled adds the seven-bit value as a signed offset to the average.
// - The tracking-disable bit stops tracking and uses the programmed holdover word.
// - Quick mode moves the tuning word to its holdover value in one step.
// - Each input word has a buffer enable in bit 0 and four mode enables in bits 4 to 1.
// - The path enable bits gate each reference out of the priority selection.
`timescale 1ns/100ps
`include "prhc_params.svh"

module prhc_core (
    input  wire logic                 core_clk,      // 200 MHz clock
    input  wire logic                 rst_n,         // Synchronous reset, active low
    input  wire logic                 reg_wr_en,     // Register write strobe
    input  wire logic                 reg_rd_en,     // Register read strobe
    input  wire logic [7:0]           reg_addr,      // Register offset
    input  wire logic [7:0]           reg_wdata,     // Write data
    output logic      [7:0]           reg_rdata,     // Read data, one cycle after strobe
    output logic                      reg_rvalid,    // Read data valid pulse
    input  wire logic                 lcm_tick,      // Common-multiple cycle strobe
    input  wire logic [3:0]           path_enable,   // Per-reference path enable
    input  wire logic [3:0]           ref_los_raw,   // Raw loss detect per reference
    input  wire logic                 phase_err_zero,// Phase detector reports zero error
    input  wire logic [7:0]           live_tune,     // Tuning word from the running loop
    input  wire logic [7:0]           avg_tune,      // Averaged tuning word
    output logic      [1:0]           sel_ref,       // Selected reference index
    output logic                      sel_valid,     // Some reference available
    output logic      [3:0]           ref_los,       // Validated loss state
    output logic                      in_holdover,   // Loop in holdover
    output logic                      div_reset,     // Divider reset pulse
    output logic                      tune_assist,   // Tuning assist pulse
    output logic      [7:0]           tune_word,     // Tuning control value
    output logic                      track_enable,  // Tuning tracking active
    output logic      [1:0]           track_bw_red,  // Tracking bandwidth reduction
    output prhc_pkg::prhc_buf_type    buf_in0,       // Input 0 buffer control
    output prhc_pkg::prhc_buf_type    buf_in1,       // Input 1 buffer control
    output prhc_pkg::prhc_buf_type    buf_in2,       // Input 2 buffer control
    output prhc_pkg::prhc_buf_type    buf_in3,       // Input 3 buffer control
    output prhc_pkg::prhc_buf_type    buf_osc        // Oscillator buffer control
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Functions

    // Hysteresis count of a timer code
    function automatic logic [8:0] hyst_cycles(input logic [2:0] code);
        hyst_cycles = (code == 3'h0) ? 9'h000 : (9'h001 << code);
    endfunction : hyst_cycles

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Register file

    logic [7:0] buf_reg [0:4];
    logic [7:0] prio_reg;
    logic [7:0] val_reg;
    logic [7:0] exit_reg;
    logic [7:0] hval_reg;
    logic [7:0] trk_reg;
    logic [7:0] rdata_next;

    wire wr_buf0 = reg_wr_en && (reg_addr == `PRHC_OFS_BUF_IN0);
    wire wr_buf1 = reg_wr_en && (reg_addr == `PRHC_OFS_BUF_IN1);
    wire wr_buf2 = reg_wr_en && (reg_addr == `PRHC_OFS_BUF_IN2);
    wire wr_buf3 = reg_wr_en && (reg_addr == `PRHC_OFS_BUF_IN3);
    wire wr_bufo = reg_wr_en && (reg_addr == `PRHC_OFS_BUF_OSC);
    wire wr_prio = reg_wr_en && (reg_addr == `PRHC_OFS_PRIORITY);
    wire wr_val  = reg_wr_en && (reg_addr == `PRHC_OFS_VALIDATION);
    wire wr_exit = reg_wr_en && (reg_addr == `PRHC_OFS_EXIT_CTRL);
    wire wr_hval = reg_wr_en && (reg_addr == `PRHC_OFS_TUNING_VALUE);
    wire wr_trk  = reg_wr_en && (reg_addr == `PRHC_OFS_TRACKING_CTRL);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 5; i++) begin
                buf_reg[i] <= `PRHC_RST_REG;
            end
            prio_reg <= `PRHC_RST_REG;
            val_reg  <= `PRHC_RST_REG;
            exit_reg <= `PRHC_RST_REG;
            hval_reg <= `PRHC_RST_REG;
            trk_reg  <= `PRHC_RST_REG;
        end else begin
            if (wr_buf0) buf_reg[0] <= reg_wdata & `PRHC_BUF_MASK;
            if (wr_buf1) buf_reg[1] <= reg_wdata & `PRHC_BUF_MASK;
            if (wr_buf2) buf_reg[2] <= reg_wdata & `PRHC_BUF_MASK;
            if (wr_buf3) buf_reg[3] <= reg_wdata & `PRHC_BUF_MASK;
            if (wr_bufo) buf_reg[4] <= reg_wdata & `PRHC_BUF_MASK;
            if (wr_prio) prio_reg   <= reg_wdata;
            if (wr_val)  val_reg    <= reg_wdata & `PRHC_VAL_MASK;
            if (wr_exit) exit_reg   <= reg_wdata & `PRHC_EXIT_MASK;
            if (wr_hval) hval_reg   <= reg_wdata & `PRHC_HVAL_MASK;
            if (wr_trk)  trk_reg    <= reg_wdata & `PRHC_TRK_MASK;
        end
    end

    always_comb begin
        case (reg_addr)
            `PRHC_OFS_BUF_IN0:       rdata_next = buf_reg[0];
            `PRHC_OFS_BUF_IN1:       rdata_next = buf_reg[1];
            `PRHC_OFS_BUF_IN2:       rdata_next = buf_reg[2];
            `PRHC_OFS_BUF_IN3:       rdata_next = buf_reg[3];
            `PRHC_OFS_BUF_OSC:       rdata_next = buf_reg[4];
            `PRHC_OFS_PRIORITY:      rdata_next = prio_reg;
            `PRHC_OFS_VALIDATION:    rdata_next = val_reg;
            `PRHC_OFS_EXIT_CTRL:     rdata_next = exit_reg;
            `PRHC_OFS_TUNING_VALUE:  rdata_next = hval_reg;
            `PRHC_OFS_TRACKING_CTRL: rdata_next = trk_reg;
            default:                 rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= reg_rd_en ? rdata_next : reg_rdata;
            reg_rvalid <= reg_rd_en;
        end
    end

    assign buf_in0 = prhc_pkg::prhc_buf_type'(buf_reg[0][`PRHC_BUF_MODE_MSB:0]);
    assign buf_in1 = prhc_pkg::prhc_buf_type'(buf_reg[1][`PRHC_BUF_MODE_MSB:0]);
    assign buf_in2 = prhc_pkg::prhc_buf_type'(buf_reg[2][`PRHC_BUF_MODE_MSB:0]);
    assign buf_in3 = prhc_pkg::prhc_buf_type'(buf_reg[3][`PRHC_BUF_MODE_MSB:0]);
    assign buf_osc = prhc_pkg::prhc_buf_type'(buf_reg[4][`PRHC_BUF_MODE_MSB:0]);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Loss-of-signal revalidation

    logic [3:0] los_reg;
    logic [3:0] los_next;
    logic [8:0] cnt_reg  [0:3];
    logic [8:0] cnt_next [0:3];

    wire [2:0] val_code = val_reg[`PRHC_VAL_MSB:0];
    wire [8:0] hyst_n   = hyst_cycles(val_code);
    wire [8:0] lim_two  = 9'(hyst_n << 1);
    wire [8:0] lim_three = 9'(lim_two + hyst_n);

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            los_next[i] = los_reg[i];
            cnt_next[i] = cnt_reg[i];
            if (ref_los_raw[i]) begin
                los_next[i] = 1'b1;
                cnt_next[i] = 9'h000;
            end else if (los_reg[i]) begin
                if (val_code == 3'h0) begin
                    los_next[i] = 1'b0;
                end else if (lcm_tick) begin
                    cnt_next[i] = 9'(cnt_reg[i] + 9'h001);
                    if (cnt_next[i] >= (((los_reg & ~(4'h1 << i)) != 4'h0) ?
                                        lim_three : lim_two)) begin
                        los_next[i] = 1'b0;
                        cnt_next[i] = 9'h000;
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            los_reg <= `PRHC_RST_LOS;
            for (int i = 0; i < 4; i++) cnt_reg[i] <= 9'h000;
        end else begin
            los_reg <= los_next;
            for (int i = 0; i < 4; i++) cnt_reg[i] <= cnt_next[i];
        end
    end

    assign ref_los = los_reg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Priority selection

    wire [3:0] avail = ~los_reg & path_enable;
    wire [1:0] prio0 = prio_reg[`PRHC_PRIO0_LSB +: 2];
    wire [1:0] prio1 = prio_reg[`PRHC_PRIO1_LSB +: 2];
    wire [1:0] prio2 = prio_reg[`PRHC_PRIO2_LSB +: 2];
    wire [1:0] prio3 = prio_reg[`PRHC_PRIO3_LSB +: 2];
    wire       any_avail = avail[prio0] | avail[prio1] | avail[prio2] | avail[prio3];
    wire [1:0] sel_next = avail[prio0] ? prio0 :
                          avail[prio1] ? prio1 :
                          avail[prio2] ? prio2 :
                          avail[prio3] ? prio3 : sel_ref;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sel_ref   <= 2'h0;
            sel_valid <= 1'b0;
        end else begin
            sel_ref   <= sel_next;
            sel_valid <= any_avail;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Holdover state machine

    prhc_pkg::prhc_state_type state_reg;
    prhc_pkg::prhc_state_type state_next;
    logic avail_d_reg;
    logic exit_ok;

    wire [1:0] exit_crit = exit_reg[`PRHC_EXIT_CRIT_MSB:0];
    wire [1:0] exit_act  = exit_reg[`PRHC_EXIT_ACT_MSB:`PRHC_EXIT_ACT_LSB];
    wire       hold      = (state_reg == prhc_pkg::ST_HOLD);
    wire       exit_evt  = hold && exit_ok;

    always_comb begin
        case (exit_crit)
            `PRHC_CRIT_PHASE: exit_ok = any_avail && phase_err_zero;
            `PRHC_CRIT_NOW:   exit_ok = 1'b1;
            default:          exit_ok = any_avail;
        endcase
    end

    always_comb begin
        case (state_reg)
            prhc_pkg::ST_TRACK: state_next = (avail_d_reg && !any_avail) ?
                                             prhc_pkg::ST_HOLD : prhc_pkg::ST_TRACK;
            prhc_pkg::ST_HOLD:  state_next = exit_ok ? prhc_pkg::ST_TRACK : prhc_pkg::ST_HOLD;
            default:            state_next = prhc_pkg::ST_HOLD;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg   <= prhc_pkg::ST_HOLD;
            avail_d_reg <= 1'b0;
            div_reset   <= 1'b0;
            tune_assist <= 1'b0;
        end else begin
            state_reg   <= state_next;
            avail_d_reg <= any_avail;
            div_reset   <= exit_evt && (exit_act == `PRHC_ACT_RESET_DIV);
            tune_assist <= exit_evt && (exit_act == `PRHC_ACT_ASSIST);
        end
    end

    assign in_holdover = hold;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Holdover tuning word

    wire       trk_dis = trk_reg[`PRHC_TRK_DIS_BIT];
    wire       quick   = trk_reg[`PRHC_QUICK_BIT];
    wire [6:0] hval    = hval_reg[`PRHC_HVAL_MSB:0];
    wire [9:0] sum     = {2'b00, avg_tune} + {{3{hval[6]}}, hval};
    wire [7:0] sum_sat = sum[9] ? 8'h00 :
                         (sum[8:0] > `PRHC_TUNE_MAX) ? 8'hff : sum[7:0];
    wire [7:0] target  = trk_dis ? {1'b0, hval} : sum_sat;
    wire [7:0] step    = (tune_word < target) ? 8'(tune_word + 8'h01) :
                         (tune_word > target) ? 8'(tune_word - 8'h01) : tune_word;
    wire [7:0] tune_next = !hold  ? live_tune :
                           quick  ? target :
                           lcm_tick ? step : tune_word;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tune_word <= 8'h00;
        end else begin
            tune_word <= tune_next;
        end
    end

    assign track_enable = !trk_dis;
    assign track_bw_red = trk_reg[`PRHC_BW_MSB:0];

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Assertions

    a_sel_first_pick: assert property (@(posedge core_clk) disable iff (!rst_n)
        avail[prio0] |=> sel_ref == $past(prio0))
        else $error("first choice not selected");
    a_sel_second_pick: assert property (@(posedge core_clk) disable iff (!rst_n)
        !avail[prio0] && avail[prio1] |=> sel_ref == $past(prio1))
        else $error("second choice not selected");
    a_sel_fourth_pick: assert property (@(posedge core_clk) disable iff (!rst_n)
        !avail[prio0] && !avail[prio1] && !avail[prio2] && avail[prio3]
        |=> sel_ref == $past(prio3))
        else $error("fourth choice not selected");
    a_los_no_hyst: assert property (@(posedge core_clk) disable iff (!rst_n)
        val_code == 3'h0 && !ref_los_raw[0] |=> !los_reg[0])
        else $error("loss held with no hysteresis");
    a_los_holds_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
        los_reg[0] && !ref_los_raw[0] && val_code != 3'h0 && cnt_reg[0] == 9'h000
        |=> los_reg[0])
        else $error("loss cleared before count");
    a_exit_div_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
        exit_evt && exit_act == 2'h0 |=> div_reset && !tune_assist)
        else $error("divider reset missing");
    a_exit_immediate: assert property (@(posedge core_clk) disable iff (!rst_n)
        hold && exit_crit == 2'h3 |=> !hold ##1 !tune_assist || exit_act == 2'h3)
        else $error("immediate exit missed");
    a_hold_direct_word: assert property (@(posedge core_clk) disable iff (!rst_n)
        hold && quick && trk_dis |=> tune_word == {1'b0, $past(hval)})
        else $error("direct holdover word not loaded");
    a_tune_ramp_up: assert property (@(posedge core_clk) disable iff (!rst_n)
        hold && !quick && lcm_tick && tune_word < target
        |=> tune_word == 8'($past(tune_word) + 8'h01))
        else $error("ramp step wrong");

endmodule : prhc_core

// file: prhc_core_test.sv
// Purpose: Self-checking bench for the reference and holdover control
// Assumes: Source model ticks every third cycle
// Notes:   Driver queues expected results, monitor compares them
`timescale 1ns/100ps
`define CHK_EQ(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL %0t got %h expected %h", $time, g, e); end end

module prhc_core_test;
    localparam int LIMIT = 20000;
    localparam int P_LOS = 4, P_TUNE = 8, P_CNT = 16, P_TEN = 32, P_BUF = 35;
    typedef struct {int lo; int w; logic [63:0] e;} prhc_note_type;
    prhc_note_type q[$];
    prhc_note_type n;
    logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic       probe = 1'b0, pez = 1'b0, clr = 1'b0, ev;
    logic [7:0] addr = 8'h00, wd = 8'h00, live = 8'h00, avg = 8'h00;
    logic [3:0] path = 4'h0, los_req = 4'hf, av;
    logic [7:0] pr, wv[10], div_cnt = 8'h00, ast_cnt = 8'h00, ed, ea, e;
    logic [1:0] es = 2'h0;
    logic [6:0] v;
    int         err_count = 0, samples_checked = 0, cyc = 0, s, t;
    logic       tick, rv, sv, hold, dres, tas, ten;
    logic [3:0] raw, los;
    logic [1:0] sel, bw;
    logic [7:0] rdata, tune;
    prhc_pkg::prhc_buf_type b0, b1, b2, b3, bo;
    wire logic [63:0] obs = {4'h0, bo, b3, b2, b1, b0, bw, ten, ast_cnt, div_cnt, tune,
                             los, sel, sv, hold};
    logic [7:0] ofs[10] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18};
    logic [7:0] msk[10] = '{8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'hff, 8'h07, 8'h0f, 8'h7f, 8'h0f};
    int         cv[6] = '{0, 1, 2, 1, 3, 7};
    logic       ov[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

    prhc_ref_src_model #(.TICK_DIV(3)) i_src (.core_clk(clk), .rst_n(rst_n),
        .los_req(los_req), .lcm_tick(tick), .ref_los_raw(raw));

    prhc_core i_dut (.core_clk(clk), .rst_n(rst_n), .reg_wr_en(wr), .reg_rd_en(rd),
        .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdata), .reg_rvalid(rv),
        .lcm_tick(tick), .path_enable(path), .ref_los_raw(raw), .phase_err_zero(pez),
        .live_tune(live), .avg_tune(avg), .sel_ref(sel), .sel_valid(sv), .ref_los(los),
        .in_holdover(hold), .div_reset(dres), .tune_assist(tas), .tune_word(tune),
        .track_enable(ten), .track_bw_red(bw), .buf_in0(b0), .buf_in1(b1),
        .buf_in2(b2), .buf_in3(b3), .buf_osc(bo));

    ////////////////////////////////////////////////////////////////
    initial begin
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        div_cnt <= clr ? 8'h00 : div_cnt + {7'h0, dres === 1'b1};
        ast_cnt <= clr ? 8'h00 : ast_cnt + {7'h0, tas === 1'b1};
        if (cyc == LIMIT) begin
            err_count++;
            give_verdict();
        end
    end

    // Oldest note pairs with each read answer or probe
    always @(posedge clk) begin
        if ((rv === 1'b1 || probe) && q.size() > 0) begin
            n = q.pop_front();
            if (n.w == 0) `CHK_EQ(rdata, n.e[7:0])
            else `CHK_EQ((obs >> n.lo) & ((64'h1 << n.w) - 1), n.e)
        end
    end

    task automatic chk(input int lo, input int w, input logic [63:0] x);
        q.push_back('{lo, w, x});
        probe <= 1'b1;
        @(posedge clk);
        probe <= 1'b0;
        @(posedge clk);
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] x);
        q.push_back('{0, 0, {56'h0, x}});
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask : rd_reg

    task automatic tk(input int k);
        repeat (k) @(posedge clk iff tick === 1'b1);
    endtask : tk

    task give_verdict();
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h2235));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk(0, 8, 64'hf1);
        for (int i = 0; i < 10; i++) begin
            rd_reg(ofs[i], 8'h00);
            wv[i] = 8'($urandom);
            wr_reg(ofs[i], wv[i]);
            rd_reg(ofs[i], wv[i] & msk[i]);
        end
        wr_reg(8'h10, 8'h5a);
        rd_reg(8'h10, 8'h00);
        chk(P_BUF, 25, {wv[4][4:0], wv[3][4:0], wv[2][4:0], wv[1][4:0], wv[0][4:0]});
        chk(P_TEN, 3, {wv[9][1:0], ~wv[9][3]});
        // Random loss and path patterns against random priorities
        wr_reg(8'h15, 8'h00);
        wr_reg(8'h16, 8'h00);
        // Paths off while priority and loss move, so a held selection stays known
        for (int i = 0; i < 24; i++) begin
            path <= 4'h0;
            pr = 8'($urandom);
            wr_reg(8'h14, pr);
            t = $urandom;
            los_req <= t[3:0];
            live <= t[15:8];
            av = ~t[3:0] & t[7:4];
            repeat (6) @(posedge clk);
            path <= t[7:4];
            repeat (2) @(posedge clk);
            ev = 1'b0;
            for (int k = 3; k >= 0; k--) begin
                if (av[pr[2*k +: 2]]) begin
                    es = pr[2*k +: 2];
                    ev = 1'b1;
                end
            end
            chk(1, 7, {t[3:0], es, ev});
        end
        // Revalidation length per timer code, alone and beside a lost input
        path <= 4'hf;
        for (int j = 0; j < 6; j++) begin
            wr_reg(8'h15, 8'h00);
            los_req <= 4'h1;
            tk(3);
            wr_reg(8'h15, 8'(cv[j]));
            los_req <= {2'b00, ov[j], 1'b0};
            tk(1);
            t = (ov[j] ? 3 : 2) << cv[j];
            if (cv[j] == 0) begin
                @(posedge clk);
            end else begin
                tk(t - 1);
                chk(P_LOS, 1, 64'h1);
                tk(1);
            end
            chk(P_LOS, 1, 64'h0);
        end
        // Exit actions, then exit criteria
        wr_reg(8'h15, 8'h00);
        wr_reg(8'h14, 8'he4);
        clr <= 1'b1;
        los_req <= 4'h0;
        tk(4);
        clr <= 1'b0;
        ed = 8'h00;
        ea = 8'h00;
        for (int a = 0; a < 4; a++) begin
            wr_reg(8'h16, 8'((a << 2) | (a & 2)));
            los_req <= 4'hf;
            tk(3);
            chk(0, 1, 64'h1);
            los_req <= 4'h4;
            live <= 8'($urandom);
            tk(3);
            ed += 8'(a == 0);
            ea += 8'(a == 3);
            chk(P_CNT, 16, {ea, ed});
            chk(0, 1, 64'h0);
            chk(P_TUNE, 8, {56'h0, live});
        end
        wr_reg(8'h16, 8'h05);
        los_req <= 4'hf;
        tk(3);
        los_req <= 4'h2;
        tk(3);
        chk(0, 1, 64'h1);
        pez <= 1'b1;
        tk(1);
        chk(0, 1, 64'h0);
        wr_reg(8'h16, 8'h03);
        los_req <= 4'hf;
        tk(3);
        chk(0, 1, 64'h0);
        // Holdover tuning word, with saturation at both ends
        wr_reg(8'h16, 8'h00);
        los_req <= 4'h0;
        tk(3);
        los_req <= 4'hf;
        tk(3);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 7'h05 : (i == 2) ? 7'h7c : 7'($urandom);
            e = (i == 0) ? 8'hfe : (i == 2) ? 8'h02 : 8'($urandom);
            avg <= e;
            s = int'(e) + int'($signed(v));
            e = i[0] ? {1'b0, v} : (s < 0) ? 8'h00 : (s > 255) ? 8'hff : 8'(s);
            wr_reg(8'h18, {4'h0, i[0], 1'b1, i[1:0]});
            wr_reg(8'h17, {1'b0, v});
            repeat (3) @(posedge clk);
            chk(P_TUNE, 8, {56'h0, e});
            chk(P_TEN, 3, {i[1:0], ~i[0]});
        end
        wr_reg(8'h18, 8'h0c);
        wr_reg(8'h17, 8'h20);
        wr_reg(8'h18, 8'h08);
        tk(1);
        wr_reg(8'h17, 8'h22);
        tk(1);
        chk(P_TUNE, 8, 64'h21);
        tk(1);
        chk(P_TUNE, 8, 64'h22);
        give_verdict();
    end
endmodule : prhc_core_test

// file: prhc_params.svh
// Purpose: Offsets, field positions and reset values of the reference and holdover control
// Assumes: Byte-wide registers addressed by their printed offsets
// Notes:   Definitions only
`ifndef PRHC_PARAMS_SVH
`define PRHC_PARAMS_SVH

`define PRHC_ADDR_W            8
`define PRHC_OFS_BUF_IN0       8'h0a
`define PRHC_OFS_BUF_IN1       8'h0b
`define PRHC_OFS_BUF_IN2       8'h0c
`define PRHC_OFS_BUF_IN3       8'h0d
`define PRHC_OFS_BUF_OSC       8'h0e
`define PRHC_OFS_PRIORITY      8'h14
`define PRHC_OFS_VALIDATION    8'h15
`define PRHC_OFS_EXIT_CTRL     8'h16
`define PRHC_OFS_TUNING_VALUE  8'h17
`define PRHC_OFS_TRACKING_CTRL 8'h18

// Buffer control fields
`define PRHC_BUF_EN_BIT        0
`define PRHC_BUF_MODE_LSB      1
`define PRHC_BUF_MODE_MSB      4
`define PRHC_BUF_MASK          8'h1f
// Priority fields, first to fourth
`define PRHC_PRIO0_LSB         0
`define PRHC_PRIO1_LSB         2
`define PRHC_PRIO2_LSB         4
`define PRHC_PRIO3_LSB         6
// Validation timer
`define PRHC_VAL_MSB           2
`define PRHC_VAL_MASK          8'h07
// Holdover exit
`define PRHC_EXIT_CRIT_MSB     1
`define PRHC_EXIT_ACT_LSB      2
`define PRHC_EXIT_ACT_MSB      3
`define PRHC_EXIT_MASK         8'h0f
`define PRHC_ACT_RESET_DIV     2'h0
`define PRHC_ACT_ASSIST        2'h3
`define PRHC_CRIT_PHASE        2'h1
`define PRHC_CRIT_NOW          2'h3
// Holdover tuning value
`define PRHC_HVAL_MSB          6
`define PRHC_HVAL_MASK         8'h7f
// Tracking control
`define PRHC_TRK_DIS_BIT       3
`define PRHC_QUICK_BIT         2
`define PRHC_BW_MSB            1
`define PRHC_TRK_MASK          8'h0f
// Reset values and tuning word limit
`define PRHC_RST_REG           8'h00
`define PRHC_RST_LOS           4'hf
`define PRHC_TUNE_MAX          9'h0ff

`endif

// file: prhc_pkg.sv
// Purpose: Types shared by the reference and holdover control
// Assumes: Nothing beyond the parameter header
// Notes:   Types only
package prhc_pkg;

    typedef struct packed {
        logic hiz;      // High-impedance mode
        logic pecl;     // Differential PECL mode
        logic ac;       // Ac coupling
        logic term;     // Internal termination
        logic en;       // Buffer enable
    } prhc_buf_type;

    typedef enum logic {ST_TRACK, ST_HOLD} prhc_state_type;

endpackage : prhc_pkg

// file: prhc_ref_src_model.sv
// Purpose: Reference source model feeding the first loop
// Assumes: Loss changes land on a common-multiple tick edge
// Notes:   Tick strobe runs free, one pulse every TICK_DIV cycles
`timescale 1ns/100ps

module prhc_ref_src_model #(
    parameter int TICK_DIV = 3
) (
    input  wire logic       core_clk,    // Loop clock
    input  wire logic       rst_n,       // Synchronous reset, active low
    input  wire logic [3:0] los_req,     // Wanted loss pattern
    output logic            lcm_tick,    // Common-multiple strobe
    output logic      [3:0] ref_los_raw  // Raw loss per input
);
    int unsigned div_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            div_reg     <= 0;
            lcm_tick    <= 1'b0;
            ref_los_raw <= 4'hf;
        end else begin
            div_reg  <= (div_reg == TICK_DIV - 1) ? 0 : div_reg + 1;
            lcm_tick <= (div_reg == TICK_DIV - 1);
            // Sources come and go only at the detector's sampling point
            if (lcm_tick) begin
                ref_los_raw <= los_req;
            end
        end
    end
endmodule : prhc_ref_src_model
